// [design/vic_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module vic_capture
	import vic_pkg::*;
#(
	parameter int CLAMP_PULSE_LEN = CLAMP_LEN,
	parameter int GAIN_PULSE_LEN  = GAIN_LEN
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic              inputPixelClock,
	input  wire logic              inputVerticalSync,
	input  wire logic              inputHorizontalSync,
	input  wire logic [PORT_W-1:0] inputPortA,
	input  wire logic [PORT_W-1:0] inputPortB,
	input  wire logic [PORT_W-1:0] inputPortC,
	input  wire logic [PORT_W-1:0] inputPortD,
	input  wire logic [PORT_W-1:0] inputPortE,
	input  wire logic [PORT_W-1:0] inputPortF,
	input  wire logic [REG_AW-1:0] regAddr,
	input  wire logic [REG_DW-1:0] regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic      [REG_DW-1:0] regRdata,
	output vic_pixel_t             pixelOut,
	output logic                   pixelValid,
	output logic                   frameStartPulse,
	output logic                   adcClampPulse,
	output logic                   adcGainPulse
);
	localparam logic [LEN_W-1:0] CLAMP_INIT = LEN_W'(CLAMP_PULSE_LEN);
	localparam logic [LEN_W-1:0] GAIN_INIT  = LEN_W'(GAIN_PULSE_LEN);

	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
		dec = (v == '0) ? v : CNT_W'(v - 1'b1);
	endfunction : dec

	function automatic logic [REG_DW-1:0] zx(input logic [CNT_W-1:0] v);
		zx = {{(REG_DW-CNT_W){1'b0}}, v};
	endfunction : zx

	// Three-stage synchroniser; only stage two and three are compared
	logic [IN_W-1:0] syn1, syn2, syn3;
	wire  [IN_W-1:0] rawIn = {inputPixelClock, inputVerticalSync, inputHorizontalSync,
		inputPortF, inputPortE, inputPortD, inputPortC, inputPortB, inputPortA};
	logic [2:0] ctl;
	wire  [2:0] ctlAgree = syn2[IN_CLK_BIT:IN_HS_BIT] ~^ syn3[IN_CLK_BIT:IN_HS_BIT];
	wire  [2:0] next_ctl = (ctlAgree & syn3[IN_CLK_BIT:IN_HS_BIT]) | (~ctlAgree & ctl);
	wire  [2:0] ctlRise  = next_ctl & ~ctl;
	wire  [2:0] ctlFall  = ~next_ctl & ctl;
	wire        pixRise  = ctlRise[IN_CLK_BIT-IN_HS_BIT];
	wire        pixFall  = ctlFall[IN_CLK_BIT-IN_HS_BIT];
	wire        vsTrail  = ctlFall[IN_VS_BIT-IN_HS_BIT];
	wire        hsTrail  = ctlFall[0];

	always_ff @(posedge mclk) begin
		syn1 <= reset ? '0 : rawIn;
		syn2 <= reset ? '0 : syn1;
		syn3 <= reset ? '0 : syn2;
		ctl  <= reset ? '0 : next_ctl;
	end

	wire [PIX_W-1:0]  dataAbc = syn3[PIX_W-1:0];
	wire [PIX_W-1:0]  dataDef = syn3[2*PIX_W-1:PIX_W];
	wire [PORT_W-1:0] curA    = syn3[PORT_W-1:0];

	// Register file: shadow written any time, active copy taken at frame start
	vic_cfg_t cfg, shadow;
	logic     frameStart;
	logic     field, lineOpen, captureThis;
	always_ff @(posedge mclk) begin
		if (reset) begin
			shadow <= CFG_RESET;
		end else if (regWrite) begin
			unique case (regAddr)
				ADDR_CTRL: begin
					shadow.mode       <= vic_mode_t'(regWdata[CTRL_MODE_LSB +: MODE_W]);
					shadow.fmt        <= vic_fmt_t'(regWdata[CTRL_FMT_LSB +: FMT_W]);
					shadow.interlaced <= regWdata[CTRL_ILACE_BIT];
				end
				ADDR_HOFF:  shadow.hOff  <= regWdata[CNT_W-1:0];
				ADDR_VOFF:  shadow.vOff  <= regWdata[CNT_W-1:0];
				ADDR_HSIZE: shadow.hSize <= regWdata[CNT_W-1:0];
				ADDR_VSIZE: shadow.vSize <= regWdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			cfg <= CFG_RESET;
		else if (frameStart)
			cfg <= shadow;
	end

	wire [REG_DW-1:0] ctrlRead = {{(REG_DW-CTRL_ILACE_BIT-1){1'b0}}, shadow.interlaced,
		shadow.fmt, shadow.mode};
	wire [REG_DW-1:0] statRead = {{(REG_DW-3){1'b0}}, captureThis, lineOpen, field};
	logic [REG_DW-1:0] rdMux;
	always_comb begin
		unique case (regAddr)
			ADDR_CTRL:   rdMux = ctrlRead;
			ADDR_HOFF:   rdMux = zx(shadow.hOff);
			ADDR_VOFF:   rdMux = zx(shadow.vOff);
			ADDR_HSIZE:  rdMux = zx(shadow.hSize);
			ADDR_VSIZE:  rdMux = zx(shadow.vSize);
			ADDR_STATUS: rdMux = statRead;
			default:     rdMux = '0;
		endcase
	end
	always_ff @(posedge mclk) begin
		regRdata <= (reset || !regRead) ? '0 : rdMux;
	end

	// YUV timing: qualifier, line reference and embedded codes
	wire isYuv     = cfg.mode == MODE_YUV;
	wire is656     = cfg.fmt == FMT_656;
	wire halfRate  = (cfg.fmt == FMT_411) || (cfg.fmt == FMT_422);
	wire qualified = pixRise & syn3[QUAL_BIT];
	logic [PORT_W-1:0] hist0, hist1, hist2;
	logic              lineRefQ, act656, vBlank656, phase;
	logic [PIX_W-1:0]  hold, rgbFirst;
	wire codeDet = qualified & (hist2 == CODE_FF) & (hist1 == CODE_00)
		& (hist0 == CODE_00) & curA[CODE_ONE_BIT];
	wire codeSav = codeDet & ~curA[CODE_H_BIT] & ~curA[CODE_V_BIT];
	wire codeEav = codeDet & curA[CODE_H_BIT];
	wire fs656   = codeDet & vBlank656 & ~curA[CODE_V_BIT];
	wire lrRise  = qualified & syn3[LREF_BIT] & ~lineRefQ;
	// Code bytes never carry video in a 656 stream, so they are dropped
	wire codeByte = is656 & ((curA == CODE_FF) | (curA == CODE_00));
	wire lineAct  = is656 ? act656 : syn3[LREF_BIT];
	wire yuvSample = qualified & lineAct & ~codeByte;
	wire yuvEvent  = yuvSample & (~halfRate | phase);
	wire lineStart = !isYuv ? hsTrail : (is656 ? codeSav : lrRise);
	assign frameStart = (isYuv && is656) ? fs656 : vsTrail;

	always_ff @(posedge mclk) begin
		if (reset) begin
			hist0     <= '0;
			hist1     <= '0;
			hist2     <= '0;
			lineRefQ  <= 1'b0;
			act656    <= 1'b0;
			vBlank656 <= 1'b1;
		end else if (qualified) begin
			hist0    <= curA;
			hist1    <= hist0;
			hist2    <= hist1;
			lineRefQ <= syn3[LREF_BIT];
			if (codeDet)
				vBlank656 <= curA[CODE_V_BIT];
			if (codeSav)
				act656 <= 1'b1;
			else if (codeEav)
				act656 <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || lineStart)
			phase <= 1'b0;
		else if (yuvSample)
			phase <= ~phase;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			hold <= '0;
		else if (yuvSample && !phase)
			hold <= dataAbc;
	end
	always_ff @(posedge mclk) begin
		if (reset)
			rgbFirst <= '0;
		else if (pixRise)
			rgbFirst <= dataAbc;
	end

	// Field identity and repeated-field skip
	logic lastField;
	wire  fieldSeen = is656 ? curA[CODE_F_BIT] : lineRefQ;
	wire  next_field = shadow.interlaced ? fieldSeen : FIELD_ODD;
	always_ff @(posedge mclk) begin
		if (reset) begin
			field       <= FIELD_ODD;
			lastField   <= FIELD_ODD;
			captureThis <= 1'b1;
		end else if (frameStart) begin
			field       <= next_field;
			lastField   <= next_field;
			captureThis <= ~shadow.interlaced | (next_field != lastField);
		end
	end

	// Window counters
	logic [CNT_W-1:0] hOffCnt, hSizeCnt, vOffCnt, vSizeCnt;
	logic pixEvent;
	always_comb begin
		unique case (cfg.mode)
			MODE_RGB_SINGLE: pixEvent = pixRise;
			MODE_RGB_DOUBLE: pixEvent = pixFall;
			MODE_YUV:        pixEvent = yuvEvent;
			default:         pixEvent = 1'b0;
		endcase
	end
	wire accept = pixEvent & ~lineStart & (hOffCnt == '0) & (hSizeCnt != '0)
		& lineOpen & captureThis;

	always_ff @(posedge mclk) begin
		if (reset) begin
			vOffCnt  <= '0;
			vSizeCnt <= '0;
			lineOpen <= 1'b0;
		end else if (frameStart) begin
			vOffCnt  <= shadow.vOff;
			vSizeCnt <= shadow.vSize;
			lineOpen <= 1'b0;
		end else if (lineStart) begin
			vOffCnt  <= dec(vOffCnt);
			vSizeCnt <= (vOffCnt == '0) ? dec(vSizeCnt) : vSizeCnt;
			lineOpen <= (vOffCnt == '0) && (vSizeCnt != '0);
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			hOffCnt  <= '0;
			hSizeCnt <= '0;
		end else if (lineStart) begin
			hOffCnt  <= cfg.hOff;
			hSizeCnt <= cfg.hSize;
		end else if (pixEvent && hOffCnt != '0) begin
			hOffCnt <= dec(hOffCnt);
		end else if (accept) begin
			hSizeCnt <= dec(hSizeCnt);
		end
	end

	// Pixel output
	logic [PIX_W-1:0] outFirst, outSecond;
	always_comb begin
		outFirst  = dataAbc;
		outSecond = '0;
		if (cfg.mode == MODE_RGB_DOUBLE) begin
			outFirst  = rgbFirst;
			outSecond = dataDef;
		end else if (isYuv && halfRate) begin
			outFirst  = hold;
			outSecond = dataAbc;
		end
	end
	always_ff @(posedge mclk) begin
		if (reset) begin
			pixelOut        <= '0;
			pixelValid      <= 1'b0;
			frameStartPulse <= 1'b0;
		end else begin
			pixelValid      <= accept;
			frameStartPulse <= frameStart;
			if (accept)
				pixelOut <= '{first: outFirst, second: outSecond, field: field};
		end
	end

	// ADC calibration pulses, counted in pixel clocks
	logic [LEN_W-1:0] clampCnt, gainCnt;
	logic             gainArm;
	always_ff @(posedge mclk) begin
		if (reset) begin
			clampCnt <= '0;
			gainCnt  <= '0;
			gainArm  <= 1'b0;
		end else begin
			if (hsTrail)
				clampCnt <= CLAMP_INIT;
			else if (pixRise && clampCnt != '0)
				clampCnt <= LEN_W'(clampCnt - 1'b1);
			// Gain pulse sits on the first line after vertical sync
			if (vsTrail)
				gainArm <= 1'b1;
			else if (hsTrail)
				gainArm <= 1'b0;
			if (hsTrail && gainArm)
				gainCnt <= GAIN_INIT;
			else if (pixRise && gainCnt != '0)
				gainCnt <= LEN_W'(gainCnt - 1'b1);
		end
	end
	assign adcClampPulse = clampCnt != '0;
	assign adcGainPulse  = gainCnt != '0;

	// Checks
	property p_single_abc;
		@(posedge mclk) disable iff (reset)
		pixelValid && cfg.mode == MODE_RGB_SINGLE |-> pixelOut.second == '0;
	endproperty
	a_single_abc: assert property (p_single_abc) else $error("single mode used D/E/F");

	property p_double_fall;
		@(posedge mclk) disable iff (reset)
		pixelValid && cfg.mode == MODE_RGB_DOUBLE |-> $past(pixFall);
	endproperty
	a_double_fall: assert property (p_double_fall) else $error("pair not on fall");

	property p_clamp;
		@(posedge mclk) disable iff (reset)
		hsTrail |=> adcClampPulse;
	endproperty
	a_clamp: assert property (p_clamp) else $error("no clamp after hsync");

	property p_window;
		@(posedge mclk) disable iff (reset)
		pixelValid |-> $past(hOffCnt) == '0 && $past(hSizeCnt) != '0 && $past(lineOpen);
	endproperty
	a_window: assert property (p_window) else $error("pixel outside window");

	property p_qualifier;
		@(posedge mclk) disable iff (reset)
		pixelValid && isYuv |-> $past(syn3[QUAL_BIT]) && $past(pixRise);
	endproperty
	a_qualifier: assert property (p_qualifier) else $error("unqualified sample");

	property p_progressive;
		@(posedge mclk) disable iff (reset)
		frameStart && !shadow.interlaced |=> field == FIELD_ODD && captureThis;
	endproperty
	a_progressive: assert property (p_progressive) else $error("progressive not odd");

	property p_skip;
		@(posedge mclk) disable iff (reset)
		pixelValid |-> captureThis;
	endproperty
	a_skip: assert property (p_skip) else $error("repeated field captured");

	property p_sav;
		@(posedge mclk) disable iff (reset)
		codeSav |=> act656 ##1 (lineOpen == $past(lineOpen) || $past(frameStart));
	endproperty
	a_sav: assert property (p_sav) else $error("code not decoded");

	property p_cfg_hold;
		@(posedge mclk) disable iff (reset)
		!frameStart |=> $stable(cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed mid frame");

	c_double: cover property (@(posedge mclk) disable iff (reset)
		pixelValid && cfg.mode == MODE_RGB_DOUBLE);
	c_code: cover property (@(posedge mclk) disable iff (reset) fs656);
	c_skip: cover property (@(posedge mclk) disable iff (reset) frameStart ##1 !captureThis);
endmodule : vic_capture
`default_nettype wire

// [design/vic_pkg.sv]
`default_nettype none
package vic_pkg;
	localparam int PORT_W     = 8;
	localparam int PIX_W      = 24;
	localparam int CNT_W      = 12;
	localparam int REG_AW     = 4;
	localparam int REG_DW     = 16;
	localparam int MODE_W     = 2;
	localparam int FMT_W      = 2;
	localparam int LEN_W      = 8;

	localparam logic [REG_AW-1:0] ADDR_CTRL   = 4'h0;
	localparam logic [REG_AW-1:0] ADDR_HOFF   = 4'h1;
	localparam logic [REG_AW-1:0] ADDR_VOFF   = 4'h2;
	localparam logic [REG_AW-1:0] ADDR_HSIZE  = 4'h3;
	localparam logic [REG_AW-1:0] ADDR_VSIZE  = 4'h4;
	localparam logic [REG_AW-1:0] ADDR_STATUS = 4'h5;

	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_FMT_LSB   = 2;
	localparam int CTRL_ILACE_BIT = 4;

	// Synchroniser vector layout: ports A..F low, then hsync, vsync, clock
	localparam int IN_W       = 51;
	localparam int IN_HS_BIT  = 48;
	localparam int IN_VS_BIT  = 49;
	localparam int IN_CLK_BIT = 50;
	localparam int QUAL_BIT   = 31;
	localparam int LREF_BIT   = 30;

	localparam int CODE_ONE_BIT = 7;
	localparam int CODE_F_BIT   = 6;
	localparam int CODE_V_BIT   = 5;
	localparam int CODE_H_BIT   = 4;
	localparam logic [PORT_W-1:0] CODE_FF = 8'hff;
	localparam logic [PORT_W-1:0] CODE_00 = 8'h00;
	localparam logic FIELD_ODD  = 1'b0;
	localparam logic FIELD_EVEN = 1'b1;

	localparam int CLAMP_LEN = 8;
	localparam int GAIN_LEN  = 8;

	typedef enum logic [MODE_W-1:0] {MODE_RGB_SINGLE, MODE_RGB_DOUBLE, MODE_YUV} vic_mode_t;
	typedef enum logic [FMT_W-1:0] {FMT_411, FMT_422, FMT_656, FMT_444} vic_fmt_t;

	typedef struct packed {
		vic_mode_t        mode;
		vic_fmt_t         fmt;
		logic             interlaced;
		logic [CNT_W-1:0] hOff;
		logic [CNT_W-1:0] vOff;
		logic [CNT_W-1:0] hSize;
		logic [CNT_W-1:0] vSize;
	} vic_cfg_t;

	typedef struct packed {
		logic [PIX_W-1:0] first;
		logic [PIX_W-1:0] second;
		logic             field;
	} vic_pixel_t;

	localparam vic_cfg_t CFG_RESET = '{mode: MODE_RGB_SINGLE, fmt: FMT_422, interlaced: 1'b0,
		hOff: 12'h000, vOff: 12'h000, hSize: 12'h000, vSize: 12'h000};
endpackage : vic_pkg
`default_nettype wire

// [design/vic_fix_note_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [verification/vic_source.sv]
`timescale 1ns/1ps
`default_nettype none
module vic_source
	import vic_pkg::*;
(
	output logic              pclk,
	output logic              vs,
	output logic              hs,
	output logic [PORT_W-1:0] a,
	output logic [PORT_W-1:0] b,
	output logic [PORT_W-1:0] c,
	output logic [PORT_W-1:0] d,
	output logic [PORT_W-1:0] e,
	output logic [PORT_W-1:0] f
);
	// Each entry is {C,B,A,F,E,D}, the order of first and second pixel
	logic [47:0] sent[$];
	initial begin
		pclk = 1'b0;
		vs = 1'b0;
		hs = 1'b0;
		{c, b, a, f, e, d} = 48'h0;
	end
	task automatic frame();
		vs = 1'b1;
		#3000;
		vs = 1'b0;
		#3000;
	endtask : frame
	// Lines other than D in YUV are inverted away from their edge, so a wrong edge reads garbage
	task automatic tick(input logic [47:0] px, input bit yuv);
		{c, b, a, f, e, d} = {px[47:24], ~px[23:0]};
		if (yuv) d = px[7:0];
		#200 pclk = 1'b1;
		#200 {c, b, a, f, e, d} = {~px[47:24], px[23:0]};
		#200 pclk = 1'b0;
		#200;
	endtask : tick
	// Clock only runs within lines, it stands still low between them
	task automatic line(input int n, input bit yuv);
		logic [47:0] px;
		bit          q;
		if (!yuv) begin
			hs = 1'b1;
			#2000 hs = 1'b0;
			#2000;
		end else begin
			tick(48'h80, 1'b1);
		end
		for (int i = 0; i < n; i++) begin
			px = {$urandom, $urandom};
			q = !yuv || !i[0];
			if (yuv) px[31:24] = q ? 8'h10 + px[31:24] % 8'hdc : 8'h00;
			if (yuv) px[39:32] = 8'h10 + px[39:32] % 8'he1;
			if (yuv) px[47:40] = 8'h10 + px[47:40] % 8'he1;
			if (yuv) px[7:6] = {q, 1'b1};
			if (q) sent.push_back(px);
			tick(px, yuv);
		end
		if (yuv) tick(48'h80, 1'b1);
	endtask : line
endmodule : vic_source
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	import vic_pkg::*;
	logic              mclk = 1'b0;
	logic              reset = 1'b1;
	logic [REG_AW-1:0] regAddr = '0;
	logic [REG_DW-1:0] regWdata = '0;
	logic              regWrite = 1'b0;
	logic              regRead = 1'b0;
	wire logic [REG_DW-1:0] regRdata;
	wire vic_pixel_t        pixelOut;
	wire logic              pixelValid, frameStartPulse, adcClampPulse, adcGainPulse;
	wire logic              pclk, vs, hs;
	wire logic [PORT_W-1:0] pa, pb, pc, pd, pe, pf;
	vic_pixel_t got[$];
	int         mismatches = 0;
	int         checks = 0;
	logic       clampSeen = 1'b0;
	logic       gainSeen = 1'b0;
	logic       frameSeen = 1'b0;
	always #50 mclk = ~mclk;
	vic_source i_vic_source(.pclk(pclk), .vs(vs), .hs(hs), .a(pa), .b(pb), .c(pc),
		.d(pd), .e(pe), .f(pf));
	vic_capture #(.CLAMP_PULSE_LEN(2), .GAIN_PULSE_LEN(2)) i_vic_capture(.mclk(mclk),
		.reset(reset), .inputPixelClock(pclk), .inputVerticalSync(vs),
		.inputHorizontalSync(hs), .inputPortA(pa), .inputPortB(pb), .inputPortC(pc),
		.inputPortD(pd), .inputPortE(pe), .inputPortF(pf), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.pixelOut(pixelOut), .pixelValid(pixelValid), .frameStartPulse(frameStartPulse),
		.adcClampPulse(adcClampPulse), .adcGainPulse(adcGainPulse));
	always @(posedge mclk) begin
		if (pixelValid === 1'b1) got.push_back(pixelOut);
		if (adcClampPulse === 1'b1) clampSeen <= 1'b1;
		if (adcGainPulse === 1'b1) gainSeen <= 1'b1;
		if (frameStartPulse === 1'b1) frameSeen <= 1'b1;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [48:0] ex, input logic [48:0] s);
		checks++;
		if (s !== ex) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, ex, s);
		end
	endtask : chk
	task automatic wr(input logic [REG_AW-1:0] ad, input logic [REG_DW-1:0] v);
		@(posedge mclk);
		regAddr <= ad;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [REG_AW-1:0] ad, input logic [REG_DW-1:0] ex);
		@(posedge mclk);
		regAddr <= ad;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1 chk("regRdata", 49'(ex), 49'(regRdata));
	endtask : rd
	task automatic cfg(input vic_mode_t m, input vic_fmt_t ft, input logic [11:0] ho,
		input logic [11:0] hz, input logic [11:0] vz);
		wr(ADDR_CTRL, 16'(m) | (16'(ft) << CTRL_FMT_LSB));
		wr(ADDR_HOFF, 16'(ho));
		wr(ADDR_VOFF, 16'h0000);
		wr(ADDR_HSIZE, 16'(hz));
		wr(ADDR_VSIZE, 16'(vz));
	endtask : cfg
	// Offset 1, size 2, one line: pixels 1 and 2 of the first line only
	task automatic run_rgb(input vic_mode_t m);
		cfg(m, FMT_422, 12'h001, 12'h002, 12'h001);
		got.delete();
		i_vic_source.line(4, 1'b0);
		#2000 chk("stale cfg count", 49'h0, 49'(got.size()));
		i_vic_source.sent.delete();
		i_vic_source.frame();
		i_vic_source.line(4, 1'b0);
		i_vic_source.line(4, 1'b0);
		#2000 chk("rgb count", 49'h2, 49'(got.size()));
		for (int k = 0; k < 2 && k < got.size(); k++) begin
			chk("first", 49'(i_vic_source.sent[k + 1][47:24]), 49'(got[k].first));
			if (m == MODE_RGB_DOUBLE) chk("second", 49'(i_vic_source.sent[k + 1][23:0]),
				49'(got[k].second));
			chk("field", 49'(FIELD_ODD), 49'(got[k].field));
		end
	endtask : run_rgb
	initial begin
		int s;
		void'($urandom(32'hc0349395));
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		for (int i = 0; i < 6; i++) rd(4'(i), (i == 0 || i == 5) ? 16'h0004 : 16'h0000);
		rd(4'hf, 16'h0000);
		wr(ADDR_HSIZE, 16'hf123);
		rd(ADDR_HSIZE, 16'h0123);
		run_rgb(MODE_RGB_SINGLE);
		chk("clamp", 49'h1, 49'(clampSeen));
		chk("gain", 49'h1, 49'(gainSeen));
		run_rgb(MODE_RGB_DOUBLE);
		chk("frame start", 49'h1, 49'(frameSeen));
		// The sample that opens the line is never counted, so capture starts one later
		cfg(MODE_YUV, FMT_444, 12'h000, 12'h003, 12'h001);
		i_vic_source.frame();
		i_vic_source.sent.delete();
		got.delete();
		i_vic_source.line(8, 1'b1);
		#2000 chk("yuv count", 49'h3, 49'(got.size()));
		s = 1;
		for (int k = 0; k < 3 && k < got.size(); k++) begin
			chk("yuv first", 49'(i_vic_source.sent[k + s][47:24]), 49'(got[k].first));
			chk("yuv second", 49'h0, 49'(got[k].second));
			chk("yuv field", 49'(FIELD_ODD), 49'(got[k].field));
		end
		end_sim();
	end
	initial begin
		#2000000;
		mismatches++;
		end_sim();
	end
endmodule : tb
`default_nettype wire
